// file: verilog/line_code_consts.svh
// constants for the 8b10b character coder: reset values and code fields
// assumes inclusion by line_code_pkg.sv and the coder modules only
`ifndef LINE_CODE_CONSTS_SVH
`define LINE_CODE_CONSTS_SVH

`define TX_INIT_RD 0
`define RX_INIT_RD 0
`define X_LSB 0
`define Y_LSB 5
`define K28_X 5'h1c
`define K28_SIX 6'h0f
`define NEG_SIX 6'h38
`define POS_SIX 6'h07
`define NEG_FOUR 4'hc
`define POS_FOUR 4'h3
`define ALT7_FOUR 4'h7
`define PRI7_FOUR 4'he

`endif

// file: verilog/line_code_pkg.sv
// types and code table functions shared by the coder modules
// assumes line_code_consts.svh is on the include path
`include "line_code_consts.svh"
package line_code_pkg;

  typedef logic [9:0] char_type;

  // six-bit codes for x = 31..0, negative column, abcdei
  localparam logic [191:0] SIX_TAB = {
    6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b,
    6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27};
  // four-bit codes for y = 7..0, negative column, fghj
  localparam logic [31:0] FOUR_TAB = {
    4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb};

  function automatic logic [2:0] ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic rd6(input logic [5:0] s, input logic rd);
    logic [2:0] n;
    n = ones(s);
    if (n > 3'h3) return 1'b1;
    if (n < 3'h3) return 1'b0;
    if (s == `POS_SIX) return 1'b1;
    if (s == `NEG_SIX) return 1'b0;
    return rd;
  endfunction

  function automatic logic rd4(input logic [3:0] f, input logic rd);
    logic [2:0] n;
    n = ones({2'h0, f});
    if (n > 3'h2) return 1'b1;
    if (n < 3'h2) return 1'b0;
    if (f == `POS_FOUR) return 1'b1;
    if (f == `NEG_FOUR) return 1'b0;
    return rd;
  endfunction

  function automatic logic k_legal(input logic [7:0] b);
    logic [4:0] x;
    logic [2:0] y;
    x = b[`X_LSB +: 5];
    y = b[`Y_LSB +: 3];
    return (x == `K28_X) || (y == 3'h7 && (x == 5'h17 || x == 5'h1b ||
           x == 5'h1d || x == 5'h1e));
  endfunction

  function automatic logic [5:0] enc6(input logic [4:0] x,
                                      input logic k, input logic rd);
    logic [5:0] c;
    c = k ? `K28_SIX : SIX_TAB[6*x +: 6];
    if (rd) begin
      if (c == `NEG_SIX) c = `POS_SIX;
      else if (ones(c) != 3'h3) c = ~c;
    end
    return c;
  endfunction

  function automatic logic [3:0] enc4(input logic [2:0] y, input logic k,
                                      input logic alt, input logic rd);
    logic [3:0] c;
    c = (y == 3'h7 && alt) ? `ALT7_FOUR : FOUR_TAB[4*y +: 4];
    if (rd) begin
      if (c == `NEG_FOUR) c = `POS_FOUR;
      else if (ones({2'h0, c}) != 3'h2) c = ~c;
    end else if (k && ones({2'h0, c}) == 3'h2 && c != `NEG_FOUR) begin
      c = ~c;
    end
    return c;
  endfunction

  function automatic char_type encode(input logic [7:0] b, input logic k,
                                      input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s;
    logic m;
    logic alt;
    x = b[`X_LSB +: 5];
    y = b[`Y_LSB +: 3];
    s = enc6(x, k && x == `K28_X, rd);
    m = rd6(s, rd);
    alt = k || (!m && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (m && (x == 5'h0b || x == 5'h0d || x == 5'h0e));
    return {s, enc4(y, k, alt, m)};
  endfunction

endpackage

// file: verilog/rd_calc.sv
// running disparity of one character over its two sub-blocks
// assumes characters in abcdei fghj order, a at bit 9
`timescale 1ns/1ns
module rd_calc (
  input wire logic [9:0] char_i,
  input wire logic rd_i,
  output logic mid_o,
  output logic rd_o
);
  always_comb begin
    mid_o = line_code_pkg::rd6(char_i[9:4], rd_i);
    rd_o = line_code_pkg::rd4(char_i[3:0], mid_o);
  end
endmodule

// file: verilog/line_code.sv
// 8b10b coder: byte to character encoder and character checker/decoder
// assumes link layer and deserialiser logic on clk_i, one character a clock
`timescale 1ns/1ns
`include "line_code_consts.svh"
module line_code #(
  parameter int TX_INIT_RD = `TX_INIT_RD,
  parameter int RX_INIT_RD = `RX_INIT_RD
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_k_i,
  output logic tx_valid_o,
  output logic [9:0] tx_char_o,
  output logic tx_err_o,
  output logic tx_rd_o,
  input wire logic rx_valid_i,
  input wire logic [9:0] rx_char_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_k_o,
  output logic rx_err_o,
  output logic rx_rd_o
);
  generate
    if (TX_INIT_RD < 0 || TX_INIT_RD > 1 || RX_INIT_RD < 0 ||
        RX_INIT_RD > 1) begin : g_bad_init
      $error("initial disparity must be 0 or 1");
    end
  endgenerate

  typedef struct packed {
    logic [9:0] tx_char;
    logic tx_valid;
    logic tx_err;
    logic tx_rd;
    logic [7:0] rx_byte;
    logic rx_k;
    logic rx_valid;
    logic rx_err;
    logic rx_rd;
  } state_type;

  state_type st;
  state_type next_st;
  line_code_pkg::char_type tx_code;
  logic tx_rd_new;
  logic rx_rd_new;
  logic [7:0] rx_dec;
  logic hit_d;
  logic hit_k;

  // find the byte whose sub-blocks appear in either disparity column
  function automatic logic [7:0] decode(input logic [9:0] c);
    logic [4:0] x;
    logic [2:0] y;
    logic kk;
    logic up;
    x = 5'h00;
    y = 3'h0;
    kk = c[9:4] == `K28_SIX || c[9:4] == ~`K28_SIX;
    up = c[9:4] == `K28_SIX;
    for (int i = 0; i < 32; i++) begin
      for (int r = 0; r < 2; r++) begin
        if (line_code_pkg::enc6(5'(i), 1'b0, 1'(r)) == c[9:4]) begin
          x = 5'(i);
        end
      end
    end
    if (kk) x = `K28_X;
    // control 28 codes share patterns across y; its six-bit fixes the column
    for (int j = 0; j < 8; j++) begin
      for (int m = 0; m < 8; m++) begin
        if (m[2] == kk && (!kk || m[0] == up) &&
            line_code_pkg::enc4(3'(j), m[2], m[1], m[0]) == c[3:0]) begin
          y = 3'(j);
        end
      end
    end
    return {y, x};
  endfunction

  always_comb begin
    tx_code = line_code_pkg::encode(tx_byte_i, tx_k_i, st.tx_rd);
  end

  rd_calc u_tx_rd (
    .char_i(tx_code),
    .rd_i(st.tx_rd),
    .mid_o(),
    .rd_o(tx_rd_new)
  );

  rd_calc u_rx_rd (
    .char_i(rx_char_i),
    .rd_i(st.rx_rd),
    .mid_o(),
    .rd_o(rx_rd_new)
  );

  always_comb begin
    rx_dec = decode(rx_char_i);
    hit_d = line_code_pkg::encode(rx_dec, 1'b0, st.rx_rd) == rx_char_i;
    hit_k = line_code_pkg::k_legal(rx_dec) &&
            line_code_pkg::encode(rx_dec, 1'b1, st.rx_rd) == rx_char_i;
  end

  always_comb begin
    next_st = st;
    next_st.tx_valid = 1'b0;
    next_st.tx_err = 1'b0;
    next_st.rx_valid = 1'b0;
    next_st.rx_err = 1'b0;
    // characters leave in acceptance order, one per clock
    if (tx_valid_i) begin
      if (tx_k_i && !line_code_pkg::k_legal(tx_byte_i)) begin
        next_st.tx_err = 1'b1;
      end else begin
        next_st.tx_char = tx_code;
        next_st.tx_valid = 1'b1;
        next_st.tx_rd = tx_rd_new;
      end
    end
    if (rx_valid_i) begin
      next_st.rx_valid = 1'b1;
      next_st.rx_byte = rx_dec;
      next_st.rx_k = hit_k;
      next_st.rx_err = !(hit_d || hit_k);
      next_st.rx_rd = rx_rd_new;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{tx_char: 10'h000, tx_valid: 1'b0, tx_err: 1'b0,
              tx_rd: 1'(TX_INIT_RD), rx_byte: 8'h00, rx_k: 1'b0,
              rx_valid: 1'b0, rx_err: 1'b0,
              rx_rd: 1'(RX_INIT_RD)};
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    tx_valid_o = st.tx_valid;
    tx_char_o = st.tx_char;
    tx_err_o = st.tx_err;
    tx_rd_o = st.tx_rd;
    rx_valid_o = st.rx_valid;
    rx_byte_o = st.rx_byte;
    rx_k_o = st.rx_k;
    rx_err_o = st.rx_err;
    rx_rd_o = st.rx_rd;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_tx_code_table: assert property (
    tx_valid_i && !(tx_k_i && !line_code_pkg::k_legal(tx_byte_i)) |=>
    tx_valid_o && tx_char_o == line_code_pkg::encode($past(tx_byte_i),
      $past(tx_k_i), $past(tx_rd_o)))
    else $error("transmitted character does not match table");

  chk_tx_bad_k: assert property (
    tx_valid_i && tx_k_i && !line_code_pkg::k_legal(tx_byte_i) |=>
    tx_err_o && !tx_valid_o && $stable(tx_rd_o))
    else $error("illegal control byte was not refused");

  chk_tx_rd_next: assert property (
    tx_valid_o |-> tx_rd_o == line_code_pkg::rd4(tx_char_o[3:0],
      line_code_pkg::rd6(tx_char_o[9:4], $past(tx_rd_o))))
    else $error("transmit disparity not derived from sent character");

  chk_tx_rd_idle: assert property (
    !tx_valid_o |-> $stable(tx_rd_o))
    else $error("transmit disparity moved without a character");

  chk_tx_six_run: assert property (
    tx_valid_o && tx_char_o[9:4] == `NEG_SIX |-> !$past(tx_rd_o))
    else $error("111000 sent from positive disparity");

  chk_tx_four_run: assert property (
    tx_valid_o && tx_char_o[3:0] == `POS_FOUR |->
    line_code_pkg::rd6(tx_char_o[9:4], $past(tx_rd_o)))
    else $error("0011 sent from negative disparity");

  chk_tx_six_pos: assert property (
    tx_valid_o && tx_char_o[9:4] == `POS_SIX |-> $past(tx_rd_o))
    else $error("000111 sent from negative disparity");

  chk_tx_four_neg: assert property (
    tx_valid_o && tx_char_o[3:0] == `NEG_FOUR |->
    !line_code_pkg::rd6(tx_char_o[9:4], $past(tx_rd_o)))
    else $error("1100 sent from positive disparity");

  chk_rx_data_back: assert property (
    rx_valid_i ##1 rx_valid_o && !rx_err_o && !rx_k_o |->
    line_code_pkg::encode(rx_byte_o, 1'b0, $past(rx_rd_o)) ==
      $past(rx_char_i))
    else $error("decoded byte does not re-encode to received character");

  chk_rx_rd_next: assert property (
    rx_valid_i |=> rx_valid_o && rx_rd_o == line_code_pkg::rd4(
      $past(rx_char_i[3:0]),
      line_code_pkg::rd6($past(rx_char_i[9:4]), $past(rx_rd_o))))
    else $error("receive disparity not derived from received character");

  chk_rx_table_err: assert property (
    rx_valid_i && line_code_pkg::encode(tx_byte_i, tx_k_i, rx_rd_o) ==
      rx_char_i && (!tx_k_i || line_code_pkg::k_legal(tx_byte_i)) |=>
    !rx_err_o)
    else $error("valid character flagged as error");

  chk_rx_k_set: assert property (
    rx_valid_o && rx_k_o |-> line_code_pkg::k_legal(rx_byte_o))
    else $error("control character outside the control set accepted");

  chk_rx_idle_quiet: assert property (
    !rx_valid_i |=> !rx_valid_o && !rx_err_o)
    else $error("receive result without a received character");

  cov_k28_5_sent: cover property (
    tx_valid_o && tx_char_o[9:4] == `K28_SIX && tx_char_o[3:0] == 4'ha);
  cov_rx_error: cover property (rx_valid_o && rx_err_o);
  cov_rx_control: cover property (rx_valid_o && rx_k_o && !rx_err_o);
  cov_tx_rd_flip: cover property (tx_valid_o && $changed(tx_rd_o));
endmodule

// file: tb/far_end.sv
// far end model: remote transceiver echoing characters back
// assumes one character clock shared with the coder, parallel characters
`timescale 1ns/1ns
module far_end (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic valid_i,
  input wire logic [9:0] char_i,
  input wire logic flip_i,
  output logic valid_o,
  output logic [9:0] char_o
);
  // echo one clock later, bit 9 leads; flip_i corrupts bit a
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o <= 1'b0;
      char_o <= 10'h155;
    end else if (valid_i) begin
      valid_o <= 1'b1;
      char_o <= char_i ^ {flip_i, 9'h000};
    end else begin
      valid_o <= 1'b0;
      char_o <= ~char_o;
    end
  end
endmodule

// file: tb/line_code_tb.sv
// self-checking bench for the line coder, looped through far_end
// assumes line_code and far_end compiled before it, 25 MHz clock
`timescale 1ns/1ns
module line_code_tb;
  typedef struct packed {
    logic [7:0] b;
    logic k;
    logic bad;
    logic flip;
    logic chk;
    logic [9:0] ch;
    logic rd;
  } item_type;
  logic clk_i, rstn_i, tx_valid_i, tx_k_i, flip;
  logic [7:0] tx_byte_i, rx_byte_o;
  logic tx_valid_o, tx_err_o, tx_rd_o, rx_valid_i;
  logic rx_valid_o, rx_k_o, rx_err_o, rx_rd_o;
  logic [9:0] tx_char_o, rx_char_i;
  item_type items[$];
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  line_code dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .tx_valid_i(tx_valid_i), .tx_byte_i(tx_byte_i), .tx_k_i(tx_k_i),
    .tx_valid_o(tx_valid_o), .tx_char_o(tx_char_o), .tx_err_o(tx_err_o),
    .tx_rd_o(tx_rd_o), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .rx_valid_o(rx_valid_o), .rx_byte_o(rx_byte_o), .rx_k_o(rx_k_o),
    .rx_err_o(rx_err_o), .rx_rd_o(rx_rd_o));
  far_end far_u (.clk_i(clk_i), .rstn_i(rstn_i), .valid_i(tx_valid_o),
    .char_i(tx_char_o), .flip_i(flip), .valid_o(rx_valid_i),
    .char_o(rx_char_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] exp,
      input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic add(input logic [7:0] b, input logic k, input logic bad,
      input logic fl, input logic chk, input logic [9:0] ch, input logic rd);
    items.push_back('{b, k, bad, fl, chk, ch, rd});
  endtask

  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #5;
    rstn_i = 1'b1;
  endtask

  // back to back requests; tx seen one clock on, rx three clocks on
  task automatic run();
    int n;
    item_type t;
    item_type r;
    n = items.size();
    for (int i = 0; i < n + 3; i++) begin
      @(posedge clk_i);
      #5;
      tx_valid_i = (i < n);
      tx_byte_i = (i < n) ? items[i].b : 8'h00;
      tx_k_i = (i < n) ? items[i].k : 1'b0;
      flip = (i >= 1 && i <= n) ? items[i - 1].flip : 1'b0;
      if (i >= 1 && i <= n) begin
        t = items[i - 1];
        check("tx_valid", 10'(!t.bad), 10'(tx_valid_o));
        check("tx_err", 10'(t.bad), 10'(tx_err_o));
        if (t.chk) check("tx_rd", 10'(t.rd), 10'(tx_rd_o));
        if (t.chk && !t.bad)
          check("tx_char", t.ch, tx_char_o);
      end
      if (i >= 3) begin
        r = items[i - 3];
        check("rx_valid", 10'(!r.bad), 10'(rx_valid_o));
        if (!r.bad) check("rx_err", 10'(r.flip), 10'(rx_err_o));
        if (!r.bad && !r.flip) check("rx_byte", {1'b0, r.k, r.b},
            {1'b0, rx_k_o, rx_byte_o});
        if (!r.bad && r.chk)
          check("rx_rd", 10'(r.rd), 10'(rx_rd_o));
      end
    end
    items.delete();
  endtask

  task automatic test_reset();
    do_reset();
    check("tx_rd", 10'h000, 10'(tx_rd_o));
    check("rx_rd", 10'h000, 10'(rx_rd_o));
    check("tx_valid", 10'h000, 10'(tx_valid_o));
    check("rx_valid", 10'h000, 10'(rx_valid_o));
    $display("test reset done");
  endtask

  task automatic test_stream();
    do_reset();
    add(8'h00, 0, 0, 0, 1, 10'h274, 0);
    add(8'h07, 0, 0, 0, 1, 10'h38b, 1);
    add(8'h00, 0, 0, 0, 1, 10'h18b, 1);
    add(8'h03, 0, 0, 0, 1, 10'h314, 0);
    add(8'hbc, 1, 0, 0, 1, 10'h0fa, 1);
    add(8'h00, 1, 1, 0, 1, 10'h000, 1);
    add(8'h07, 0, 0, 0, 1, 10'h074, 0);
    run();
    $display("test stream done");
  endtask

  task automatic test_ctrl_set();
    do_reset();
    for (int y = 0; y < 8; y++) begin
      add(8'(y * 32 + 28), 1, 0, 0, 0, 10'h000, 0);
    end
    add(8'hf7, 1, 0, 0, 0, 10'h000, 0);
    add(8'hfb, 1, 0, 0, 0, 10'h000, 0);
    add(8'hfd, 1, 0, 0, 0, 10'h000, 0);
    add(8'hfe, 1, 0, 0, 0, 10'h000, 0);
    add(8'h1b, 1, 1, 0, 0, 10'h000, 0);
    add(8'hff, 1, 1, 0, 0, 10'h000, 0);
    run();
    $display("test control set done");
  endtask

  task automatic test_corrupt();
    do_reset();
    add(8'h00, 0, 0, 1, 1, 10'h274, 0);
    add(8'h07, 0, 0, 0, 1, 10'h38b, 1);
    run();
    $display("test corrupt done");
  endtask

  initial begin
    tx_valid_i = 1'b0;
    tx_byte_i = 8'h00;
    tx_k_i = 1'b0;
    flip = 1'b0;
    test_reset();
    test_stream();
    test_ctrl_set();
    test_corrupt();
    results();
  end
endmodule
